/* core/rcr_pkg.sv */
// Purpose: shared constants and types of the receiver clock configuration
// Assumes: 200 MHz system clock, 32-bit APB, byte registers in low lanes
// Notes:   register byte address is four times the register index
package rcr_pkg;
    // =========================================================
    // bus and register map
    localparam int         APB_AW      = 8;
    localparam int         REG_W       = 8;
    localparam logic [5:0] IDX_REF_SEL = 6'h0d;
    localparam logic [5:0] IDX_CLK_CTL = 6'h0e;
    localparam logic [5:0] IDX_PLL_HI  = 6'h0f;
    localparam logic [5:0] IDX_PLL_MID = 6'h10;
    localparam logic [5:0] IDX_FRAC_LO = 6'h11;
    localparam logic [5:0] IDX_DET_ST  = 6'h12;
    localparam logic [5:0] IDX_RATE_ST = 6'h13;
    localparam logic [1:0] WORD_LANE   = 2'h0;

    // =========================================================
    // field positions and reset values
    localparam int         REF_SEL_BIT = 3;
    localparam int         CTL_W       = 5;
    localparam int         P_LSB       = 4;
    localparam int         JHI_W       = 4;
    localparam int         JLO_LSB     = 6;
    localparam int         DHI_W       = 6;
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic       SEL_RXREF   = 1'b0;

    // =========================================================
    // recovered rate codes and divider codes
    localparam logic [1:0] RATE_NONE = 2'h0;
    localparam logic [1:0] RATE_128  = 2'h1;
    localparam logic [1:0] RATE_256  = 2'h2;
    localparam logic [1:0] RATE_512  = 2'h3;
    localparam logic [1:0] DIV_NONE  = 2'h0;

    // =========================================================
    // timing: frame-rate bands turned into clock periods
    localparam int CLK_HZ      = 200000000;
    localparam int FS_512_HZ   = 54000;
    localparam int FS_256_HZ   = 108000;
    localparam int FS_128_HZ   = 216000;
    localparam int FS_MIN_HZ   = 20000;
    localparam int PER_512_CYC = CLK_HZ / FS_512_HZ;
    localparam int PER_256_CYC = CLK_HZ / FS_256_HZ;
    localparam int PER_128_CYC = CLK_HZ / FS_128_HZ;

    // =========================================================
    // carriers
    typedef struct packed {
        logic       unlockFreeRun;
        logic       autoMute;
        logic [1:0] divider;
        logic       outEnable;
    } rcr_clk_ctl_s;

    typedef struct packed {
        logic [3:0]  preDiv;
        logic [5:0]  intMult;
        logic [13:0] frac;
    } rcr_pll_cfg_s;
endpackage

/* core/rcr_sync.sv */
// Purpose: three-stage synchroniser with agreement filter, per bit
// Assumes: inputs asynchronous to clk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module rcr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // pins and filtered levels
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // =========================================================
    // stage one is read only by stage two
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pinIn;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a bit follows only while the last two stages agree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            level <= '0;
        end else begin
            level <= ((s2 ^ s3) & level) | (~(s2 ^ s3) & s3);
        end
    end
endmodule // rcr_sync

/* core/rcr_rate_meter.sv */
// Purpose: frame-period measurement and maximum recovered rate estimate
// Assumes: frameTick is a one-cycle pulse per incoming frame
// Notes:   no frame within TIMEOUT_CYC cycles reports rate not determined
`timescale 1ns/1ps
module rcr_rate_meter
    import rcr_pkg::*;
#(
    parameter int CNT_W       = 14,
    parameter int TIMEOUT_CYC = CLK_HZ / FS_MIN_HZ
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // frame events and estimate
    input  wire logic       frameTick,
    output logic      [1:0] rate
);
    localparam logic [CNT_W-1:0] TMO = CNT_W'(TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] P512 = CNT_W'(PER_512_CYC);
    localparam logic [CNT_W-1:0] P256 = CNT_W'(PER_256_CYC);
    localparam logic [CNT_W-1:0] P128 = CNT_W'(PER_128_CYC);

    logic [CNT_W-1:0] period;

    // =========================================================
    // cycles since the last frame, saturating at the timeout
    always_ff @(posedge clk) begin
        if (!rstn) begin
            period <= '0;
        end else if (frameTick) begin
            period <= '0;
        end else if (period != TMO) begin
            period <= period + 1'b1;
        end
    end

    // slower frames leave room for a higher multiple of fs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rate <= RATE_NONE;
        end else if (period == TMO) begin
            rate <= RATE_NONE;
        end else if (frameTick) begin
            if (period >= P512) begin
                rate <= RATE_512;
            end else if (period >= P256) begin
                rate <= RATE_256;
            end else if (period >= P128) begin
                rate <= RATE_128;
            end else begin
                rate <= RATE_NONE;
            end
        end
    end

    chk_rate_timeout: assert property (@(posedge clk) disable iff (!rstn)
        period == TMO |=> rate == RATE_NONE)
        else $error("rate not cleared after frame timeout");
endmodule // rcr_rate_meter

/* core/rcr_top.sv */
// Purpose: clock section of an audio interface receiver with APB registers
// Assumes: pins asynchronous; audio words from logic on clk
// Notes:   registers sit at four times their index; byte data in lanes 7:0
//
// Functional notes
// - output enable 0 floats recovered clock pin; 1 drives recovered clock.
// - divider code 00,01,10,11 gives division by 1,2,4,8.
// - auto mute set and both unlocks present forces audio output low.
// - on unlock the clock stops if behaviour bit 0, free runs if 1.
// - pre-divider upper nibble of first register; J spans two registers.
// - fraction upper six bits in second register, low eight in third.
// - status bit 0 follows burst format detection.
// - status bit 1 follows encoded disc stream detection.
// - rate field codes none, 128, 256, 512 times sample rate.
// - estimate frame rate, derive maximum rate, load it into status.
// - reference select 0 picks receiver reference input, 1 master clock.
`timescale 1ns/1ps
module rcr_top
    import rcr_pkg::*;
#(
    parameter int AUDIO_W     = 24,
    parameter int TIMEOUT_CYC = CLK_HZ / FS_MIN_HZ
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [APB_AW-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // pins from the line decoder and clock recovery pll
    input  wire logic               clockRecoveryPllClk,
    input  wire logic               decoderUnlock,
    input  wire logic               pllUnlock,
    input  wire logic               frameSync,
    input  wire logic               burstFormatDetect,
    input  wire logic               encodedDiscDetect,
    // recovered clock pin
    output logic                    recoveredClockOut,
    output logic                    recoveredClockOutEnN,
    // reference multiplier pll
    input  wire logic               receiverReferenceInput,
    input  wire logic               masterClockIn,
    output logic                    refClockToPll,
    output rcr_pll_cfg_s            pllCfg,
    // audio data path
    input  wire logic [AUDIO_W-1:0] audioIn,
    output logic      [AUDIO_W-1:0] audioOut
);
    localparam int NSYNC = 6;

    rcr_clk_ctl_s       clkCtl;
    logic               refSelect;
    logic [REG_W-1:0]   pllHi;
    logic [REG_W-1:0]   pllMid;
    logic [REG_W-1:0]   fracLo;
    logic [NSYNC-1:0]   lvl;
    logic               pllLvl;
    logic               pllPrev;
    logic               frameLvl;
    logic               framePrev;
    logic               bothUnlocked;
    logic               anyUnlocked;
    logic [1:0]         maxRate;
    logic [2:0]         divCnt;
    logic               next_clkOut;
    logic               clockStopped;
    logic               muteNow;
    logic [5:0]         index;
    logic               aligned;
    logic               hit;
    logic               wrEn;
    logic [REG_W-1:0]   rdByte;
    logic [REG_W-1:0]   detStatus;
    logic [REG_W-1:0]   rateStatus;

    // =========================================================
    // pin synchronisers
    rcr_sync #(
        .W     (NSYNC)
    ) u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .pinIn ({clockRecoveryPllClk, decoderUnlock, pllUnlock,
                 frameSync, burstFormatDetect, encodedDiscDetect}),
        .level (lvl)
    );

    assign pllLvl       = lvl[5];
    assign frameLvl     = lvl[2];
    assign bothUnlocked = lvl[4] & lvl[3];
    assign anyUnlocked  = lvl[4] | lvl[3];

    // edge history of the filtered pll clock and frame sync
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pllPrev   <= 1'b0;
            framePrev <= 1'b0;
        end else begin
            pllPrev   <= pllLvl;
            framePrev <= frameLvl;
        end
    end

    // =========================================================
    // rate estimation
    rcr_rate_meter #(
        .CNT_W       (14),
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_meter (
        .clk         (clk),
        .rstn        (rstn),
        .frameTick   (frameLvl & ~framePrev),
        .rate        (maxRate)
    );

    // =========================================================
    // apb decode: zero wait states, unmapped or unaligned gives error
    assign index   = paddr[7:2];
    assign aligned = paddr[1:0] == WORD_LANE;
    assign hit     = aligned && index >= IDX_REF_SEL && index <= IDX_RATE_ST;
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign wrEn    = psel & penable & pwrite & hit;

    // status views; upper bits tied to zero
    assign detStatus  = {6'h00, lvl[0], lvl[1]};
    assign rateStatus = {6'h00, maxRate};

    // read mux, captured in the setup cycle so prdata is a flop
    always_comb begin
        rdByte = REG_RST;
        case (index)
            IDX_REF_SEL: rdByte = {4'h0, refSelect, 3'h0};
            IDX_CLK_CTL: rdByte = {3'h0, clkCtl};
            IDX_PLL_HI:  rdByte = pllHi;
            IDX_PLL_MID: rdByte = pllMid;
            IDX_FRAC_LO: rdByte = fracLo;
            IDX_DET_ST:  rdByte = detStatus;
            IDX_RATE_ST: rdByte = rateStatus;
            default:     rdByte = REG_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= hit ? {24'h000000, rdByte} : '0;
        end
    end

    // =========================================================
    // writable registers; status indices have no storage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            refSelect <= SEL_RXREF;
            clkCtl    <= rcr_clk_ctl_s'(REG_RST[CTL_W-1:0]);
            pllHi     <= REG_RST;
            pllMid    <= REG_RST;
            fracLo    <= REG_RST;
        end else if (wrEn) begin
            case (index)
                IDX_REF_SEL: refSelect <= pwdata[REF_SEL_BIT];
                IDX_CLK_CTL: clkCtl    <= rcr_clk_ctl_s'(pwdata[CTL_W-1:0]);
                IDX_PLL_HI:  pllHi     <= pwdata[REG_W-1:0];
                IDX_PLL_MID: pllMid    <= pwdata[REG_W-1:0];
                IDX_FRAC_LO: fracLo    <= pwdata[REG_W-1:0];
                default:     ;
            endcase
        end
    end

    // =========================================================
    // multiplier pll fields; the K and P range checks are software's
    assign pllCfg.preDiv  = pllHi[REG_W-1:P_LSB];
    assign pllCfg.intMult = {pllHi[JHI_W-1:0], pllMid[REG_W-1:JLO_LSB]};
    assign pllCfg.frac    = {pllMid[DHI_W-1:0], fracLo};

    // reference clock source, a plain clock mux ahead of the pll
    assign refClockToPll = refSelect ? masterClockIn : receiverReferenceInput;

    // =========================================================
    // recovered clock divider and stop-on-unlock
    assign clockStopped = anyUnlocked & ~clkCtl.unlockFreeRun;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            divCnt <= '0;
        end else if (clockStopped) begin
            divCnt <= '0;
        end else if (pllLvl && !pllPrev) begin
            divCnt <= divCnt + 1'b1;
        end
    end

    // divided clock is a counter tap, so the duty cycle stays 50 %
    always_comb begin
        case (clkCtl.divider)
            DIV_NONE: next_clkOut = pllLvl;
            2'h1:     next_clkOut = divCnt[0];
            2'h2:     next_clkOut = divCnt[1];
            2'h3:     next_clkOut = divCnt[2];
            default:  next_clkOut = pllLvl;
        endcase
        if (clockStopped) begin
            next_clkOut = 1'b0;
        end
    end

    // pin driver, enable is active low while driving
    always_ff @(posedge clk) begin
        if (!rstn) begin
            recoveredClockOut    <= 1'b0;
            recoveredClockOutEnN <= 1'b1;
        end else begin
            recoveredClockOut    <= next_clkOut;
            recoveredClockOutEnN <= ~clkCtl.outEnable;
        end
    end

    // =========================================================
    // automatic mute needs both decoder and pll unlocked
    assign muteNow = clkCtl.autoMute & bothUnlocked;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            audioOut <= '0;
        end else begin
            audioOut <= muteNow ? '0 : audioIn;
        end
    end

    // =========================================================
    // checks
    sequence apbWrite(logic [5:0] idx);
        psel && penable && pwrite && aligned && index == idx;
    endsequence

    sequence apbStatusRead;
        psel && !penable && !pwrite && aligned &&
        (index == IDX_DET_ST || index == IDX_RATE_ST);
    endsequence

    chk_pin_float: assert property (@(posedge clk) disable iff (!rstn)
        !clkCtl.outEnable |=> recoveredClockOutEnN)
        else $error("recovered clock pin driven while disabled");

    chk_pass_through: assert property (@(posedge clk) disable iff (!rstn)
        clkCtl.divider == DIV_NONE && !clockStopped
        |=> recoveredClockOut == $past(pllLvl))
        else $error("undivided clock does not follow pll");

    chk_auto_mute: assert property (@(posedge clk) disable iff (!rstn)
        clkCtl.autoMute && bothUnlocked |=> audioOut == '0)
        else $error("audio not muted on unlock");

    chk_no_mute: assert property (@(posedge clk) disable iff (!rstn)
        !clkCtl.autoMute |=> audioOut == $past(audioIn))
        else $error("audio altered with auto mute off");

    chk_clock_stop: assert property (@(posedge clk) disable iff (!rstn)
        anyUnlocked && !clkCtl.unlockFreeRun |=> !recoveredClockOut)
        else $error("recovered clock runs during unlock");

    chk_prediv_field: assert property (@(posedge clk) disable iff (!rstn)
        apbWrite(IDX_PLL_HI)
        |=> pllCfg.preDiv == $past(pwdata[7:4])
            && pllCfg.intMult[5:2] == $past(pwdata[3:0]))
        else $error("pre-divider or multiplier field wrong");

    chk_frac_field: assert property (@(posedge clk) disable iff (!rstn)
        apbWrite(IDX_PLL_MID)
        |=> pllCfg.frac[13:8] == $past(pwdata[5:0])
            && pllCfg.intMult[1:0] == $past(pwdata[7:6]))
        else $error("fraction upper bits wrong");

    chk_status_zero: assert property (@(posedge clk) disable iff (!rstn)
        apbStatusRead |=> prdata[31:2] == '0)
        else $error("status upper bits not zero");

    chk_rate_report: assert property (@(posedge clk) disable iff (!rstn)
        psel && !penable && aligned && index == IDX_RATE_ST
        |=> prdata[1:0] == $past(maxRate))
        else $error("rate field does not show estimate");

    // the stored select bit, loaded from the written bit, decides the source
    chk_ref_select: assert property (@(posedge clk) disable iff (!rstn)
        apbWrite(IDX_REF_SEL)
        |=> refClockToPll == ($past(pwdata[REF_SEL_BIT])
            ? masterClockIn : receiverReferenceInput))
        else $error("reference clock source wrong");
endmodule // rcr_top

/* tb/test_receiver_clock_recovery_config.sv */
// Purpose: self-checking bench of the receiver clock configuration block
// Assumes: zero-wait apb slave; pin inputs pass a four-edge filter
// Notes:   rate timeout cut to 4000 cycles to keep the run short
`timescale 1ns/1ps
module test_receiver_clock_recovery_config
    import rcr_pkg::*;
;
    // ==========================================================
    // signals and model state
    localparam int TOUT = 4000;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [APB_AW-1:0]  paddr = '0;
    logic [31:0]        pwdata = '0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               pllClk = 1'b0;
    logic               decUnl = 1'b0;
    logic               pllUnl = 1'b0;
    logic               frameSync = 1'b0;
    logic               burst = 1'b0;
    logic               encDisc = 1'b0;
    logic               recOut;
    logic               recOutEnN;
    logic               refIn = 1'b0;
    logic               mclkIn = 1'b0;
    logic               refToPll;
    rcr_pll_cfg_s       pllCfg;
    logic [23:0]        audioIn = '0;
    logic [23:0]        audioOut;
    logic [23:0]        audPrev = '0;
    logic [31:0]        seed = 32'h223d;
    logic [31:0]        rd;
    logic [31:0]        rnd;
    logic [7:0]         hiB;
    logic [7:0]         midB;
    logic [7:0]         loB;
    int                 pTab [4] = '{1, 1, 2, 2};
    int                 jTab [4] = '{12, 8, 8, 7};
    int                 dTab [4] = '{0, 7075, 7075, 2818};
    logic               err;
    logic               pllRun = 1'b0;
    logic [7:0]         regModel [int];
    int                 pllCnt = 0;
    int                 fails = 0;
    int                 compares = 0;
    int                 cycles = 0;
    int                 outR;
    int                 plR;
    int                 per [4] = '{3800, 2000, 1000, 500};

    rcr_top #(.AUDIO_W(24), .TIMEOUT_CYC(TOUT)) uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clockRecoveryPllClk(pllClk), .decoderUnlock(decUnl),
        .pllUnlock(pllUnl), .frameSync(frameSync),
        .burstFormatDetect(burst), .encodedDiscDetect(encDisc),
        .recoveredClockOut(recOut), .recoveredClockOutEnN(recOutEnN),
        .receiverReferenceInput(refIn), .masterClockIn(mclkIn),
        .refClockToPll(refToPll), .pllCfg(pllCfg),
        .audioIn(audioIn), .audioOut(audioOut));

    // ==========================================================
    // clock, free-running stimulus, timeout
    always #2.5 clk = ~clk;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // pll clock is kept slow: the block samples it with clk
    always @(posedge clk) begin : stim
        logic [31:0] r;
        r = xs();
        audioIn <= r[23:0];
        refIn <= r[24];
        mclkIn <= r[25];
        audPrev <= audioIn;
        cycles <= cycles + 1;
        if (pllRun) begin
            pllCnt <= pllCnt + 1;
            if (pllCnt % 4 == 3) pllClk <= ~pllClk;
        end
        if (cycles == 70000) begin
            fails++;
            report_and_stop();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 1, pready);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        if (a >= 8'h34 && a <= 8'h44) regModel[a] = d[7:0];
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk("prdata", e, rd);
    endtask

    // rising edges of recovered clock and pll clock over 256 cycles
    task automatic count();
        logic po;
        logic pp;
        repeat (16) @(posedge clk);
        outR = 0;
        plR = 0;
        po = recOut;
        pp = pllClk;
        repeat (256) begin
            @(posedge clk);
            #1;
            if (recOut && !po) outR++;
            if (pllClk && !pp) plR++;
            po = recOut;
            pp = pllClk;
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // reset values and read-only places
        for (int a = 8'h34; a <= 8'h4c; a += 4) rdChk(a, 0);
        chk("enN", 1, recOutEnN);
        wr(8'h48, 32'hff);
        wr(8'h4c, 32'hff);
        rdChk(8'h48, 0);
        rdChk(8'h4c, 0);
        // unmapped and unaligned places answer with an error
        wr(8'h50, 32'h5a);
        chk("slverr", 1, err);
        rdChk(8'h39, 0);
        chk("slverr", 1, err);
        // legal P, J, D settings; random upper lanes must be ignored
        for (int k = 0; k < 4; k++) begin
            rnd = xs();
            hiB = 8'(pTab[k] * 16 + jTab[k] / 4);
            midB = 8'(jTab[k] % 4 * 64 + dTab[k] / 256);
            loB = 8'(dTab[k] % 256);
            wr(8'h3c, {rnd[31:8], hiB});
            wr(8'h40, {rnd[23:0], midB});
            wr(8'h44, {rnd[15:0], rnd[31:24], loB});
            for (int a = 8'h3c; a <= 8'h44; a += 4) rdChk(a, regModel[a]);
            chk("preDiv", pTab[k], pllCfg.preDiv);
            chk("intMult", jTab[k], pllCfg.intMult);
            chk("frac", dTab[k], pllCfg.frac);
        end
        // reference select in both settings
        for (int s = 1; s >= 0; s--) begin
            wr(8'h34, s << 3);
            repeat (6) begin
                @(posedge clk);
                #1;
                chk("refToPll", s ? mclkIn : refIn, refToPll);
            end
        end
        // detection status follows the pins
        for (int i = 0; i < 4; i++) begin
            burst <= i[0];
            encDisc <= i[1];
            repeat (8) @(posedge clk);
            rdChk(8'h48, i);
        end
        // every divider code, then unlock with stop and free run
        pllRun <= 1'b1;
        for (int dv = 0; dv < 4; dv++) begin
            wr(8'h38, (dv << 1) | 1);
            count();
            chk("enN", 0, recOutEnN);
            chk("divOk", 1, (outR - (plR >> dv)) inside {-1, 0, 1});
        end
        for (int k = 0; k < 3; k++) begin
            wr(8'h38, (k == 2) ? 8'h13 : 8'h03);
            decUnl <= (k == 0);
            pllUnl <= (k != 0);
            count();
            if (k < 2) chk("stopRises", 0, outR);
            else chk("freeOk", 1, (outR - (plR >> 1)) inside {-1, 0, 1});
        end
        wr(8'h38, 8'h00);
        @(posedge clk);
        #1;
        chk("enN", 1, recOutEnN);
        // audio mute needs the bit and both unlocks
        for (int i = 0; i < 8; i++) begin
            wr(8'h38, i[2] << 3);
            decUnl <= i[0];
            pllUnl <= i[1];
            repeat (8) @(posedge clk);
            repeat (4) begin
                @(posedge clk);
                #1;
                chk("audioOut", (i == 7) ? 0 : audPrev, audioOut);
            end
        end
        decUnl <= 1'b0;
        pllUnl <= 1'b0;
        // rate estimate from frame period, then loss of frames
        for (int j = 0; j < 4; j++) begin
            repeat (3) begin
                frameSync <= 1'b1;
                repeat (4) @(posedge clk);
                frameSync <= 1'b0;
                repeat (per[j] - 4) @(posedge clk);
            end
            rdChk(8'h4c, 3 - j);
        end
        repeat (TOUT + 100) @(posedge clk);
        rdChk(8'h4c, RATE_NONE);
        // second reset clears the configuration
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdChk(8'h3c, 0);
        chk("pllCfg", 0, pllCfg);
        report_and_stop();
    end
endmodule // test_receiver_clock_recovery_config
